// File: verilog/idt_defines.svh
// bit positions, reset values and timing counts of the interrupt and dma trigger block
`ifndef IDT_DEFINES_SVH
`define IDT_DEFINES_SVH

// condition flag and condition enable bit positions
`define IDT_CF_START      0
`define IDT_CF_RESTART    1
`define IDT_CF_STOP       2
`define IDT_CF_ADDRESS    3
`define IDT_CF_WRITE      4
`define IDT_CF_ACK_TIME   5
`define IDT_CF_COUNT      6
`define IDT_CF_W          7

// error flag and error enable bit positions
`define IDT_EF_NACK       0
`define IDT_EF_COLLISION  1
`define IDT_EF_TIMEOUT    2
`define IDT_EF_W          3

// buffer status bit positions, any of them forces a nack
`define IDT_ST_TX_WRITE   0
`define IDT_ST_RX_READ    1
`define IDT_ST_TX_UNDER   2
`define IDT_ST_RX_OVER    3
`define IDT_ST_W          4

// bit counts within one nine-bit segment
`define IDT_BYTE_EDGE     4'h8
`define IDT_ACK_EDGE      4'h9
`define IDT_ACK_RISE      4'h8

// reset values
`define IDT_RST_BYTE      8'h00
`define IDT_RST_LINES     3'h7

// time-out length in ticks of the selected time-out source
`define IDT_TOUT_TICKS    8'h19

// receive fifo shape
`define IDT_DATA_W        8
`define IDT_FIFO_DEPTH    8

`endif

// File: verilog/idt_pkg.sv
// types shared by the interrupt and dma trigger block
package idt_pkg;

	// segment phase of the bus transfer
	typedef enum logic [3:0] {
		PH_IDLE    = 4'h1,
		PH_ADDR    = 4'h2,
		PH_ADDR_LO = 4'h4,
		PH_DATA    = 4'h8
	} idt_phase_t;

	// whole state of the core except the receive fifo, which is held in idt_fifo
	typedef struct packed {
		logic [2:0] scl_m;
		logic [2:0] sda_m;
		logic       scl_f;
		logic       sda_f;
		idt_phase_t phase;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic       matched;
		logic       client_active;
		logic       host_active;
		logic       read_dir;
		logic       data_ind;
		logic       clock_stretch;
		logic [7:0] tx_buf;
		logic       tx_empty;
		logic       tx_mask;
		logic [7:0] tx_byte;
		logic       tx_load;
		logic [7:0] rx_buf;
		logic       rx_full;
		logic [7:0] byte_cnt;
		logic [6:0] cond;
		logic [2:0] err;
		logic [3:0] status;
		logic [7:0] addr_low;
		logic [7:0] addr_high;
		logic [7:0] tout_cnt;
		logic       stop_pend;
		logic       stop_req;
		logic       nack_send;
		logic       mod_reset;
		logic       tx_flag;
		logic       rx_flag;
		logic       gen_flag;
		logic       err_flag;
		logic       irq;
		logic       wake;
	} idt_state_t;

endpackage

// File: verilog/idt_fifo.sv
// receive fifo between the shift side and the receive buffer
`timescale 1ns/100ps
module idt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rstn_in,
	input  wire logic             flush_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} idt_fifo_state_t;

	idt_fifo_state_t q;
	idt_fifo_state_t d;
	logic            full;
	logic            empty;

	// extra pointer bit tells full from empty
	assign empty        = (q.wp == q.rp);
	assign full         = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
	assign wr_ready_out = ~full;
	assign rd_valid_out = ~empty;
	assign rd_data_out  = q.mem[q.rp[AW-1:0]];

	// push and pop, flush wins over both
	always_comb begin
		d = q;
		if (wr_valid_in && !full) begin
			d.mem[q.wp[AW-1:0]] = wr_data_in;
			d.wp = q.wp + 1'b1;
		end
		if (rd_ready_in && !empty) begin
			d.rp = q.rp + 1'b1;
		end
		if (flush_in) begin
			d.wp = '0;
			d.rp = '0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// File: verilog/idt_core.sv
// interrupt flags, dma triggers and bus error logic of the i2c module
`timescale 1ns/100ps
`include "idt_defines.svh"
module idt_core (
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       addr_match_in,
	input  wire logic       ten_bit_mode_in,
	input  wire logic       address_buffer_disable_in,
	input  wire logic       host_start_done_in,
	input  wire logic       host_write_in,
	input  wire logic       sda_release_in,
	input  wire logic       clock_release_in,
	input  wire logic       transmit_buffer_write_in,
	input  wire logic [7:0] transmit_buffer_data_in,
	input  wire logic       receive_buffer_read_in,
	input  wire logic       clear_buffers_in,
	input  wire logic       byte_counter_load_in,
	input  wire logic [7:0] byte_counter_value_in,
	input  wire logic [6:0] condition_enable_in,
	input  wire logic [6:0] condition_clear_in,
	input  wire logic [2:0] error_enable_in,
	input  wire logic [2:0] error_clear_in,
	input  wire logic       general_interrupt_enable_in,
	input  wire logic       error_interrupt_enable_in,
	input  wire logic       transmit_interrupt_enable_in,
	input  wire logic       receive_interrupt_enable_in,
	input  wire logic [3:0] timeout_ticks_in,
	input  wire logic [1:0] timeout_source_select_in,
	output logic            transmit_flag_out,
	output logic            receive_flag_out,
	output logic            general_flag_out,
	output logic            error_flag_out,
	output logic            interrupt_out,
	output logic            wake_out,
	output logic [6:0]      condition_flag_out,
	output logic [2:0]      error_register_out,
	output logic [3:0]      buffer_status_out,
	output logic            transmit_buffer_empty_out,
	output logic            receive_buffer_full_out,
	output logic [7:0]      receive_buffer_out,
	output logic [7:0]      byte_counter_out,
	output logic            client_active_out,
	output logic            host_active_out,
	output logic            clock_stretch_out,
	output logic            read_dir_out,
	output logic            data_ind_out,
	output logic [7:0]      address_buffer_low_out,
	output logic [7:0]      address_buffer_high_out,
	output logic [7:0]      shift_byte_out,
	output logic [7:0]      tx_byte_out,
	output logic            tx_load_out,
	output logic            nack_send_out,
	output logic            module_reset_out,
	output logic            stop_request_out
);

	idt_pkg::idt_state_t q;
	idt_pkg::idt_state_t d;
	logic                fifo_push;
	logic [7:0]          fifo_wdata;
	logic                fifo_ready;
	logic                fifo_valid;
	logic                fifo_pop;
	logic [7:0]          fifo_rdata;

	// true while the device takes part in a transfer
	function automatic logic is_active(input idt_pkg::idt_state_t s);
		return s.client_active | s.host_active;
	endfunction

	// transmit next byte into the shifter, or note an underflow
	function automatic idt_pkg::idt_state_t load_tx(input idt_pkg::idt_state_t s);
		idt_pkg::idt_state_t r;
		r = s;
		if (!s.tx_empty) begin
			r.tx_byte  = s.tx_buf;
			r.tx_load  = 1'b1;
			r.tx_empty = 1'b1;
			r.tx_mask  = 1'b0;
		end else if (s.byte_cnt != `IDT_RST_BYTE) begin
			r.status[`IDT_ST_TX_UNDER] = 1'b1;
		end
		return r;
	endfunction

	// bytes wait here when the receive buffer is still full
	idt_fifo #(
		.WIDTH (`IDT_DATA_W),
		.DEPTH (`IDT_FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk_in   (ref_clk_in),
		.rstn_in      (rstn_in),
		.flush_in     (clear_buffers_in),
		.wr_valid_in  (fifo_push),
		.wr_ready_out (fifo_ready),
		.wr_data_in   (fifo_wdata),
		.rd_valid_out (fifo_valid),
		.rd_ready_in  (fifo_pop),
		.rd_data_out  (fifo_rdata)
	);

	// next state
	always_comb begin
		logic       scl_fall;
		logic       scl_rise;
		logic       start_det;
		logic       stop_det;
		logic       byte_done;
		logic       ack_done;
		logic       dir_tx;
		logic       push;
		logic [3:0] edge_no;
		logic [3:0] status_old;
		scl_fall   = 1'b0;
		scl_rise   = 1'b0;
		start_det  = 1'b0;
		stop_det   = 1'b0;
		byte_done  = 1'b0;
		ack_done   = 1'b0;
		dir_tx     = 1'b0;
		push       = 1'b0;
		edge_no    = 4'h0;
		status_old = q.status;
		d = q;
		d.tx_load   = 1'b0;
		d.nack_send = 1'b0;
		d.mod_reset = 1'b0;
		fifo_wdata  = q.shift;

		// three-stage pin filter, level moves when stages two and three agree
		d.scl_m = {q.scl_m[1:0], scl_in};
		d.sda_m = {q.sda_m[1:0], sda_in};
		if (q.scl_m[1] == q.scl_m[2]) begin
			d.scl_f = q.scl_m[2];
		end
		if (q.sda_m[1] == q.sda_m[2]) begin
			d.sda_f = q.sda_m[2];
		end
		scl_fall  = q.scl_f & ~d.scl_f;
		scl_rise  = ~q.scl_f & d.scl_f;
		start_det = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
		stop_det  = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;

		// software clears first so a same-cycle hardware set wins
		d.cond = q.cond & ~condition_clear_in;
		d.err  = q.err & ~error_clear_in;
		if (clock_release_in) begin
			d.clock_stretch = 1'b0;
		end
		if (byte_counter_load_in) begin
			d.byte_cnt = byte_counter_value_in;
		end
		if (host_start_done_in) begin
			d.host_active = 1'b1;
		end
		dir_tx = d.client_active ? q.read_dir : host_write_in;

		// bus conditions
		if (start_det) begin
			if (q.phase != idt_pkg::PH_IDLE) begin
				d.cond[`IDT_CF_RESTART] = 1'b1;
			end else begin
				d.cond[`IDT_CF_START] = 1'b1;
			end
			d.phase   = idt_pkg::PH_ADDR;
			d.bitcnt  = 4'hf; // start fall wraps to 0
			d.matched = 1'b0;
		end
		if (stop_det) begin
			d.cond[`IDT_CF_STOP] = 1'b1;
			d.phase         = idt_pkg::PH_IDLE;
			d.client_active = 1'b0;
			d.host_active   = 1'b0;
			d.clock_stretch = 1'b0;
			d.stop_pend     = 1'b0;
		end

		// bit sampling on rising clock, ack seen on the ninth pulse
		if (scl_rise && q.phase != idt_pkg::PH_IDLE) begin
			if (q.bitcnt < `IDT_ACK_RISE) begin
				d.shift = {q.shift[6:0], d.sda_f};
			end else if (d.sda_f && is_active(q)) begin
				d.err[`IDT_EF_NACK] = 1'b1;
			end
		end

		// falling clock counts the nine-bit segment
		if (scl_fall && q.phase != idt_pkg::PH_IDLE) begin
			edge_no   = q.bitcnt + 4'h1;
			byte_done = (edge_no == `IDT_BYTE_EDGE);
			ack_done  = (edge_no == `IDT_ACK_EDGE);
			d.bitcnt  = ack_done ? 4'h0 : edge_no;
		end

		// eighth falling edge: address or data byte complete
		if (byte_done) begin
			unique case (q.phase)
				idt_pkg::PH_ADDR, idt_pkg::PH_ADDR_LO: begin
					if (addr_match_in) begin
						d.matched = 1'b1;
						d.cond[`IDT_CF_ADDRESS] = 1'b1;
						if (condition_enable_in[`IDT_CF_ADDRESS]) begin
							d.clock_stretch = 1'b1;
						end
						if (address_buffer_disable_in) begin
							push = 1'b1;
						end else if (q.phase == idt_pkg::PH_ADDR) begin
							d.addr_low = q.shift;
						end else begin
							d.addr_high = q.shift;
						end
						if (q.phase == idt_pkg::PH_ADDR) begin
							d.read_dir = q.shift[0];
							d.data_ind = 1'b0;
						end
					end else begin
						d.matched = 1'b0;
					end
				end
				idt_pkg::PH_DATA: begin
					if (!dir_tx && is_active(q)) begin
						push       = 1'b1;
						d.data_ind = 1'b1;
						if (q.client_active) begin
							d.cond[`IDT_CF_WRITE] = 1'b1;
						end
					end
				end
				idt_pkg::PH_IDLE: begin
				end
			endcase
		end

		// ninth falling edge: acknowledge finished
		if (ack_done) begin
			if (q.phase == idt_pkg::PH_DATA || q.matched) begin
				if (q.client_active || q.matched) begin
					d.cond[`IDT_CF_ACK_TIME] = 1'b1;
					if (condition_enable_in[`IDT_CF_ACK_TIME] && !q.sda_f) begin
						d.clock_stretch = 1'b1;
					end
				end
			end
			unique case (q.phase)
				idt_pkg::PH_ADDR, idt_pkg::PH_ADDR_LO: begin
					if (!q.matched || q.sda_f) begin
						d.phase = idt_pkg::PH_IDLE;
					end else if (q.phase == idt_pkg::PH_ADDR && ten_bit_mode_in
						&& !q.read_dir) begin
						d.phase = idt_pkg::PH_ADDR_LO;
					end else begin
						d.phase         = idt_pkg::PH_DATA;
						d.client_active = 1'b1;
						if (q.read_dir) begin
							d = load_tx(d);
						end
					end
				end
				idt_pkg::PH_DATA: begin
					if (q.byte_cnt != `IDT_RST_BYTE) begin
						d.byte_cnt = q.byte_cnt - 8'h01;
						if (q.byte_cnt == 8'h01) begin
							d.cond[`IDT_CF_COUNT] = 1'b1;
						end
					end
					if (dir_tx && !q.sda_f && d.byte_cnt != `IDT_RST_BYTE) begin
						d = load_tx(d);
					end
				end
				idt_pkg::PH_IDLE: begin
				end
			endcase
		end

		// transmit buffer write and its error
		if (transmit_buffer_write_in) begin
			if (!q.tx_empty) begin
				d.status[`IDT_ST_TX_WRITE] = 1'b1;
			end else begin
				d.tx_buf   = transmit_buffer_data_in;
				d.tx_empty = 1'b0;
				d.tx_mask  = 1'b0;
			end
		end

		// receive byte into the fifo, refused byte is an overrun
		if (push) begin
			if (!fifo_ready) begin
				d.status[`IDT_ST_RX_OVER] = 1'b1;
			end
		end
		fifo_push = push;

		// read of the receive buffer and refill from the fifo
		if (receive_buffer_read_in) begin
			if (q.rx_full) begin
				d.rx_full = 1'b0;
			end else begin
				d.status[`IDT_ST_RX_READ] = 1'b1;
			end
		end
		fifo_pop = fifo_valid && !d.rx_full && !clear_buffers_in;
		if (fifo_pop) begin
			d.rx_buf  = fifo_rdata;
			d.rx_full = 1'b1;
		end

		// clear buffers empties both sides and hides the transmit request
		if (clear_buffers_in) begin
			d.tx_empty = 1'b1;
			d.tx_mask  = 1'b1;
			d.rx_full  = 1'b0;
			d.status   = 4'h0;
		end

		// a newly set buffer error sends a nack and flags it
		if ((d.status & ~status_old) != 4'h0) begin
			d.nack_send         = 1'b1;
			d.err[`IDT_EF_NACK] = 1'b1;
		end

		// time-out counter runs on the selected source while clock is low
		if (q.phase != idt_pkg::PH_IDLE && !d.scl_f) begin
			if (timeout_ticks_in[timeout_source_select_in]) begin
				d.tout_cnt = q.tout_cnt + 8'h01;
			end
		end else begin
			d.tout_cnt = `IDT_RST_BYTE;
		end
		if (d.tout_cnt == `IDT_TOUT_TICKS) begin
			d.tout_cnt = `IDT_RST_BYTE;
			d.err[`IDT_EF_TIMEOUT] = 1'b1;
			if (q.client_active) begin
				d.client_active = 1'b0;
				d.clock_stretch = 1'b0;
				d.mod_reset     = 1'b1;
			end
			if (q.host_active) begin
				d.stop_pend = 1'b1;
			end
		end

		// collision: data low while the lines should both be high
		if (sda_release_in && d.scl_f && !d.sda_f && !start_det) begin
			d.err[`IDT_EF_COLLISION] = 1'b1;
			d.mod_reset = 1'b1;
		end

		// module reset drops the transfer but keeps flags for software
		if (d.mod_reset) begin
			d.phase         = idt_pkg::PH_IDLE;
			d.bitcnt        = 4'h0;
			d.matched       = 1'b0;
			d.client_active = 1'b0;
			d.clock_stretch = 1'b0;
		end

		// stop is only requested once the bus is seen idle
		d.stop_req = d.stop_pend & d.scl_f & d.sda_f;

		// level flags from the next state, registered for the outputs
		d.tx_flag  = is_active(d) && d.byte_cnt != `IDT_RST_BYTE
			&& d.tx_empty && !d.tx_mask;
		d.rx_flag  = is_active(d) && d.rx_full;
		d.gen_flag = |(d.cond & condition_enable_in);
		d.err_flag = |(d.err & error_enable_in);
		d.wake     = d.gen_flag & general_interrupt_enable_in;
		d.irq      = d.wake | (d.err_flag & error_interrupt_enable_in)
			| (d.tx_flag & transmit_interrupt_enable_in)
			| (d.rx_flag & receive_interrupt_enable_in);
	end

	// state register, lines reset to the idle-high level
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q          <= '0;
			q.scl_m    <= `IDT_RST_LINES;
			q.sda_m    <= `IDT_RST_LINES;
			q.scl_f    <= 1'b1;
			q.sda_f    <= 1'b1;
			q.phase    <= idt_pkg::PH_IDLE;
			q.tx_empty <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// every output is a state flip-flop
	assign transmit_flag_out         = q.tx_flag;
	assign receive_flag_out          = q.rx_flag;
	assign general_flag_out          = q.gen_flag;
	assign error_flag_out            = q.err_flag;
	assign interrupt_out             = q.irq;
	assign wake_out                  = q.wake;
	assign condition_flag_out        = q.cond;
	assign error_register_out        = q.err;
	assign buffer_status_out         = q.status;
	assign transmit_buffer_empty_out = q.tx_empty;
	assign receive_buffer_full_out   = q.rx_full;
	assign receive_buffer_out        = q.rx_buf;
	assign byte_counter_out          = q.byte_cnt;
	assign client_active_out         = q.client_active;
	assign host_active_out           = q.host_active;
	assign clock_stretch_out         = q.clock_stretch;
	assign read_dir_out              = q.read_dir;
	assign data_ind_out              = q.data_ind;
	assign address_buffer_low_out    = q.addr_low;
	assign address_buffer_high_out   = q.addr_high;
	assign shift_byte_out            = q.shift;
	assign tx_byte_out               = q.tx_byte;
	assign tx_load_out               = q.tx_load;
	assign nack_send_out             = q.nack_send;
	assign module_reset_out          = q.mod_reset;
	assign stop_request_out          = q.stop_req;

endmodule

// File: dv/idt_core_checker.sv
// concurrent checks on the ports of the interrupt and dma trigger core
`timescale 1ns/100ps
`include "idt_defines.svh"
module idt_core_checker (
	input wire logic       ref_clk_in,
	input wire logic       rstn_in,
	input wire logic [6:0] condition_enable_in,
	input wire logic [2:0] error_enable_in,
	input wire logic       transmit_buffer_write_in,
	input wire logic       clear_buffers_in,
	input wire logic       transmit_flag_out,
	input wire logic       receive_flag_out,
	input wire logic       general_flag_out,
	input wire logic       error_flag_out,
	input wire logic [6:0] condition_flag_out,
	input wire logic [2:0] error_register_out,
	input wire logic [3:0] buffer_status_out,
	input wire logic       transmit_buffer_empty_out,
	input wire logic       receive_buffer_full_out,
	input wire logic [7:0] byte_counter_out,
	input wire logic       client_active_out,
	input wire logic       host_active_out,
	input wire logic       nack_send_out,
	input wire logic       module_reset_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	// enables are registered with the flags, hence the one-cycle look back
	tx_cond_a: assert property (
		transmit_flag_out |-> (client_active_out || host_active_out)
		&& byte_counter_out != 8'h00 && transmit_buffer_empty_out) else $error("tx flag cond");
	gen_or_a: assert property (
		general_flag_out == |(condition_flag_out & $past(condition_enable_in)))
		else $error("general flag");
	err_or_a: assert property (
		error_flag_out == |(error_register_out & $past(error_enable_in))) else $error("err flag");
	tx_write_a: assert property (
		transmit_buffer_write_in && transmit_buffer_empty_out
		|=> !transmit_buffer_empty_out && !transmit_flag_out) else $error("tx write");
	buf_clear_a: assert property (
		clear_buffers_in |=> !receive_buffer_full_out && !transmit_flag_out
		&& buffer_status_out == 4'h0) else $error("clear buffers");
	rx_full_a: assert property (
		receive_flag_out |-> receive_buffer_full_out) else $error("rx flag without data");
	tout_client_a: assert property (
		client_active_out ##1 $rose(error_register_out[`IDT_EF_TIMEOUT])
		|-> !client_active_out && module_reset_out) else $error("time-out kept client");
	cnt_zero_a: assert property (
		$rose(condition_flag_out[`IDT_CF_COUNT]) |-> byte_counter_out == 8'h00)
		else $error("count flag");
	buf_err_a: assert property (
		$rose(|buffer_status_out) |-> nack_send_out && error_register_out[`IDT_EF_NACK])
		else $error("buffer error nack");
	coll_reset_a: assert property (
		$rose(error_register_out[`IDT_EF_COLLISION]) |-> module_reset_out)
		else $error("collision reset");

	cover property ($rose(transmit_flag_out));
	cover property ($rose(error_register_out[`IDT_EF_TIMEOUT]));
	cover property ($rose(error_register_out[`IDT_EF_COLLISION]));
endmodule

bind idt_core idt_core_checker idt_core_checker_i (
	.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .condition_enable_in(condition_enable_in),
	.error_enable_in(error_enable_in), .transmit_buffer_write_in(transmit_buffer_write_in),
	.clear_buffers_in(clear_buffers_in), .transmit_flag_out(transmit_flag_out),
	.receive_flag_out(receive_flag_out), .general_flag_out(general_flag_out),
	.error_flag_out(error_flag_out), .condition_flag_out(condition_flag_out),
	.error_register_out(error_register_out), .buffer_status_out(buffer_status_out),
	.transmit_buffer_empty_out(transmit_buffer_empty_out),
	.receive_buffer_full_out(receive_buffer_full_out), .byte_counter_out(byte_counter_out),
	.client_active_out(client_active_out), .host_active_out(host_active_out),
	.nack_send_out(nack_send_out), .module_reset_out(module_reset_out)
);

// File: dv/idt_host_model.sv
// remote bus host: open-drain conditions and byte clocking at 320 ns
`timescale 1ns/100ps
module idt_host_model (
	output logic scl_low_out,
	output logic sda_low_out
);
	localparam int Q = 80; // quarter link period

	// released lines float high through the pull-ups
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	task automatic start_cond();
		sda_low_out = 1'b1;
		#(2*Q) scl_low_out = 1'b1;
		#(2*Q);
	endtask
	task automatic restart_cond();
		sda_low_out = 1'b0;
		#Q scl_low_out = 1'b0;
		#Q;
		start_cond();
	endtask
	task automatic stop_cond();
		sda_low_out = 1'b1;
		#Q scl_low_out = 1'b0;
		#(2*Q) sda_low_out = 1'b0;
		#(2*Q);
	endtask
	// ack pull stands in for whichever party answers; the core drives no data pin
	task automatic send_byte(logic [7:0] b, logic ack);
		logic [8:0] v;
		v = {b, !ack};
		for (int i = 8; i >= 0; i--) begin
			sda_low_out = !v[i];
			#Q scl_low_out = 1'b0;
			#(2*Q) scl_low_out = 1'b1;
			#Q;
		end
		sda_low_out = 1'b0;
	endtask
endmodule

// File: dv/tb.sv
// self-checking bench of the interrupt and dma trigger core
`timescale 1ns/100ps
`include "idt_defines.svh"
module tb;
	logic       clk, rstn, scl_low, sda_low, match, abd, sda_rel, clk_rel, hsd;
	logic       txw, rxr, clr, cntl, gie, txf, rxf, genf, errf, wake, txe, ca, ha, irq;
	logic [7:0] txd, cntv, adr, d, rxb, bc, alo, txb;
	logic [6:0] cen, ccl, cf;
	logic [2:0] een, ecl, er;
	logic [3:0] tick, bs;
	logic [1:0] tsel;
	int         bad_count, n_compared, cnt, seed;
	logic [7:0] rxq[$];

	idt_host_model host_i (.scl_low_out(scl_low), .sda_low_out(sda_low));
	idt_core idt_core_i (
		.ref_clk_in(clk), .rstn_in(rstn), .scl_in(!scl_low), .sda_in(!sda_low),
		.addr_match_in(match), .ten_bit_mode_in(1'b0), .address_buffer_disable_in(abd),
		.host_start_done_in(hsd), .host_write_in(1'b0), .sda_release_in(sda_rel),
		.clock_release_in(clk_rel), .transmit_buffer_write_in(txw),
		.transmit_buffer_data_in(txd), .receive_buffer_read_in(rxr), .clear_buffers_in(clr),
		.byte_counter_load_in(cntl), .byte_counter_value_in(cntv),
		.condition_enable_in(cen), .condition_clear_in(ccl), .error_enable_in(een),
		.error_clear_in(ecl), .general_interrupt_enable_in(gie),
		.error_interrupt_enable_in(1'b1), .transmit_interrupt_enable_in(1'b1),
		.receive_interrupt_enable_in(1'b1), .timeout_ticks_in(tick),
		.timeout_source_select_in(tsel), .transmit_flag_out(txf), .receive_flag_out(rxf),
		.general_flag_out(genf), .error_flag_out(errf), .interrupt_out(irq), .wake_out(wake),
		.condition_flag_out(cf), .error_register_out(er), .buffer_status_out(bs),
		.transmit_buffer_empty_out(txe), .receive_buffer_full_out(),
		.receive_buffer_out(rxb), .byte_counter_out(bc), .client_active_out(ca),
		.host_active_out(ha), .clock_stretch_out(), .read_dir_out(), .data_ind_out(),
		.address_buffer_low_out(alo), .address_buffer_high_out(), .shift_byte_out(),
		.tx_byte_out(txb), .tx_load_out(), .nack_send_out(), .module_reset_out(),
		.stop_request_out()
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// one-cycle strobes: tx write, rx read, clear, clock release, host start
	task automatic strobe(logic [4:0] s, logic [7:0] dat);
		@(posedge clk);
		{txw, rxr, clr, clk_rel, hsd} <= s;
		txd <= dat;
		@(posedge clk);
		{txw, rxr, clr, clk_rel, hsd} <= 5'h00;
		cyc(2);
	endtask
	task automatic clr_flags(logic [6:0] c, logic [2:0] e);
		@(posedge clk);
		ccl <= c;
		ecl <= e;
		@(posedge clk);
		ccl <= 7'h00;
		ecl <= 3'h0;
		cyc(2);
	endtask
	// filter lag plus margin before the ninth-fall effects are read
	task automatic xfer(logic [7:0] b, logic ack);
		host_i.send_byte(b, ack);
		cyc(6);
	endtask
	task automatic load_cnt(int n);
		@(posedge clk);
		cntl <= 1'b1;
		cntv <= 8'(n);
		@(posedge clk);
		cntl <= 1'b0;
		cnt = n;
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the few tens of microseconds of traffic
	initial begin
		#2ms;
		bad_count++;
		complete_run();
	end

	initial begin
		seed = $urandom(32'h0354);
		{rstn, match, abd, sda_rel, clk_rel, hsd, txw, rxr, clr, cntl} = 10'h000;
		{txd, cntv, ccl, ecl, tick, tsel} = 32'h0;
		cen = 7'h7e;
		een = 3'h7;
		gie = 1'b1;
		cyc(16);
		rstn <= 1'b1;
		cyc(4);
		chk("tx empty", 8'h01, txe);
		chk("high flags", 8'h00, {txf, rxf, genf, errf});
		// client write, address buffers on, start enable off at first
		load_cnt(3);
		match <= 1'b1;
		host_i.start_cond();
		cyc(6);
		chk("start flag", 8'h01, cf[`IDT_CF_START]);
		chk("general masked", 8'h00, genf);
		cen <= 7'h7f;
		adr = {7'($urandom), 1'b0};
		xfer(adr, 1'b1);
		chk("address buffer", adr, alo);
		chk("address flag", 8'h01, cf[`IDT_CF_ADDRESS]);
		chk("client active", 8'h01, ca);
		chk("ack time", 8'h01, cf[`IDT_CF_ACK_TIME]);
		chk("wake", 8'h01, wake);
		chk("interrupt", 8'h01, irq);
		strobe(5'h02, 8'h00);
		clr_flags(7'h7f, 3'h0);
		chk("general clear", 8'h00, genf);
		for (int i = 0; i < 3; i++) begin
			d = 8'($urandom);
			rxq.push_back(d);
			xfer(d, 1'b1);
			cnt--;
			chk("rx flag", 8'h01, rxf);
			chk("write flag", 8'h01, cf[`IDT_CF_WRITE]);
			chk("write hold", 8'h01, genf);
			chk("rx data", rxq.pop_front(), rxb);
			chk("byte count", 8'(cnt), bc);
			strobe(5'h08, 8'h00);
			chk("rx flag read", 8'h00, rxf);
			clr_flags(7'h10, 3'h0);
			chk("write clear", 8'h00, cf[`IDT_CF_WRITE]);
		end
		chk("count flag", 8'h01, cf[`IDT_CF_COUNT]);
		// same address again, now delivered through the receive buffer
		abd <= 1'b1;
		host_i.restart_cond();
		cyc(6);
		chk("restart flag", 8'h01, cf[`IDT_CF_RESTART]);
		xfer(adr, 1'b1);
		chk("address in rx", adr, rxb);
		chk("rx flag address", 8'h01, rxf);
		strobe(5'h08, 8'h00);
		host_i.stop_cond();
		cyc(6);
		chk("stop flag", 8'h01, cf[`IDT_CF_STOP]);
		clr_flags(7'h7f, 3'h7);
		// client read of three bytes, first byte preloaded, last one refused
		load_cnt(3);
		d = 8'($urandom);
		strobe(5'h10, d);
		chk("tx flag idle", 8'h00, txf);
		host_i.start_cond();
		xfer(adr | 8'h01, 1'b1);
		chk("tx byte", d, txb);
		chk("tx flag", 8'h01, txf);
		strobe(5'h04, 8'h00);
		chk("tx flag cleared", 8'h00, txf);
		for (int i = 0; i < 3; i++) begin
			strobe(5'h10, 8'($urandom));
			chk("tx flag written", 8'h00, txf);
			xfer(8'hff, i < 2);
			cnt--;
			chk("tx flag next", 8'(cnt != 0), txf);
			chk("read count", 8'(cnt), bc);
		end
		chk("nack flag", 8'h01, er[`IDT_EF_NACK]);
		chk("error flag", 8'h01, errf);
		host_i.stop_cond();
		clr_flags(7'h7f, 3'h0);
		chk("error kept", 8'h01, er[`IDT_EF_NACK]);
		clr_flags(7'h00, 3'h7);
		chk("error flag clear", 8'h00, errf);
		// time-out while addressed, clock line held low, other sources noisy
		abd <= 1'b0;
		host_i.start_cond();
		xfer(adr, 1'b1);
		tsel <= 2'($urandom);
		for (int i = 1; i <= 25; i++) begin
			@(posedge clk);
			tick <= 4'h1 << tsel;
			@(posedge clk);
			tick <= ~(4'h1 << tsel);
			if (i == 24) begin
				cyc(2);
				chk("timeout early", 8'h00, er[`IDT_EF_TIMEOUT]);
			end
		end
		@(posedge clk);
		tick <= 4'h0;
		cyc(2);
		chk("timeout flag", 8'h01, er[`IDT_EF_TIMEOUT]);
		chk("client dropped", 8'h00, ca);
		host_i.stop_cond();
		clr_flags(7'h7f, 3'h7);
		// read of an empty receive buffer
		strobe(5'h08, 8'h00);
		chk("rx read error", 8'h01, bs[`IDT_ST_RX_READ]);
		chk("forced nack", 8'h01, er[`IDT_EF_NACK]);
		strobe(5'h04, 8'h00);
		chk("status cleared", 8'h00, bs);
		clr_flags(7'h7f, 3'h7);
		// data held low where the engine expects a released line
		host_i.start_cond();
		sda_rel <= 1'b1;
		xfer(8'h00, 1'b0);
		sda_rel <= 1'b0;
		chk("collision", 8'h01, er[`IDT_EF_COLLISION]);
		chk("collision error", 8'h01, errf);
		host_i.stop_cond();
		strobe(5'h01, 8'h00);
		chk("host active", 8'h01, ha);
		complete_run();
	end
endmodule
